// ===== test/arsc_chk_assertions.sv
// assertion checker for the start compare block
// assumes binding to arsc_start_compare; sees only its ports
`timescale 1ns/1ps
`include "arsc_consts.vh"

module arsc_chk (
    input wire        I_CORE_CLK,
    input wire        I_RST_B,
    input wire        I_CMD_WR,
    input wire [7:0]  I_CMD_CODE,
    input wire        I_SECTOR_DONE,
    input wire        I_HOST_HW_RESET,
    input wire [7:0]  I_TF_DRV_HEAD,
    input wire        I_BREADY,
    input wire        I_RREADY,
    input wire        O_BVALID,
    input wire [1:0]  O_BRESP,
    input wire        O_RVALID,
    input wire [31:0] O_RDATA,
    input wire        O_ARREADY,
    input wire        O_AUTO_READ_GO,
    input wire        O_AUTO_READ_BLOCK,
    input wire        O_TF_LOAD,
    input wire        O_DRIVE_READY,
    input wire        O_WRITE_FAULT,
    input wire        O_SEEK_DONE,
    input wire        O_DRV0_STATUS_ACTIVE
);
    // ======================================================================
    // helpers
    wire is_rd = (I_CMD_CODE == `ARSC_CMD_READ_SEC) || (I_CMD_CODE == `ARSC_CMD_READ_SEC_NR)
               || (I_CMD_CODE == `ARSC_CMD_READ_MULT) || (I_CMD_CODE == `ARSC_CMD_READ_DMA)
               || (I_CMD_CODE == `ARSC_CMD_READ_DMA_NR);
    wire any_st = O_DRIVE_READY || O_WRITE_FAULT || O_SEEK_DONE;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);

    // ======================================================================
    // assertions
    a_result_exclusive: assert property (!(O_AUTO_READ_GO && O_AUTO_READ_BLOCK))
        else $error("go and block together");
    a_go_needs_read: assert property (O_AUTO_READ_GO |-> $past(I_CMD_WR && is_rd))
        else $error("go without read command");
    a_block_needs_read: assert property (O_AUTO_READ_BLOCK |-> $past(I_CMD_WR && is_rd))
        else $error("block without read command");
    a_load_after_done: assert property (O_TF_LOAD |-> $past(I_SECTOR_DONE))
        else $error("load without sector done");
    a_drive0_active: assert property (!I_TF_DRV_HEAD[4] |=> O_DRV0_STATUS_ACTIVE)
        else $error("drive 0 selected but status inactive");
    a_status_gated: assert property (!O_DRV0_STATUS_ACTIVE |-> !any_st)
        else $error("status bits shown while inactive");
    // three sync flops, agree stage, status clear, output flop: six edges, seen at the seventh sample
    a_hwrst_clears: assert property (I_HOST_HW_RESET [*7] |-> !any_st)
        else $error("status not cleared by host reset");
    a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
    a_rdata_upper: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_read_busy: assert property (O_RVALID |-> !O_ARREADY)
        else $error("read address accepted while answer pending");

    c_go: cover property (O_AUTO_READ_GO);
    c_block: cover property (O_AUTO_READ_BLOCK);
    c_load: cover property (O_TF_LOAD);
    c_hwrst: cover property (I_HOST_HW_RESET [*6] ##1 !any_st);
endmodule // arsc_chk

bind arsc_start_compare arsc_chk arsc_chk_i (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B), .I_CMD_WR(I_CMD_WR),
    .I_CMD_CODE(I_CMD_CODE), .I_SECTOR_DONE(I_SECTOR_DONE),
    .I_HOST_HW_RESET(I_HOST_HW_RESET), .I_TF_DRV_HEAD(I_TF_DRV_HEAD),
    .I_BREADY(I_BREADY), .I_RREADY(I_RREADY), .O_BVALID(O_BVALID), .O_BRESP(O_BRESP),
    .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .O_ARREADY(O_ARREADY),
    .O_AUTO_READ_GO(O_AUTO_READ_GO), .O_AUTO_READ_BLOCK(O_AUTO_READ_BLOCK),
    .O_TF_LOAD(O_TF_LOAD), .O_DRIVE_READY(O_DRIVE_READY), .O_WRITE_FAULT(O_WRITE_FAULT),
    .O_SEEK_DONE(O_SEEK_DONE), .O_DRV0_STATUS_ACTIVE(O_DRV0_STATUS_ACTIVE));

// ===== test/arsc_host_tf.sv
// host task-file model: {drive/head, cyl high, cyl low, sector}
// assumes the bench sets values and the block's load pulse advances them
`timescale 1ns/1ps

module arsc_host_tf (
    input  wire        i_clk,
    input  wire        i_rst_b,
    input  wire        i_set,
    input  wire [31:0] i_set_val,
    input  wire        i_load,
    input  wire [31:0] i_nxt,
    output reg  [31:0] o_tf
);
    // ======================================================================
    // task file; a software write wins over a hardware load
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tf <= 32'h0000_0001;
        end else if (i_set) begin
            o_tf <= i_set_val;
        end else if (i_load) begin
            o_tf <= i_nxt;
        end
    end
endmodule // arsc_host_tf

// ===== test/test_arsc_start_compare.sv
// self-checking bench for the start compare block
// assumes 20 MHz clock, AXI4-Lite register access and the host model
`timescale 1ns/1ps
`include "arsc_consts.vh"

module test_arsc_start_compare;
    reg         clk, rst_b, awv, wv, brdy, arv, rrdy, cmd_wr, sdone, hwrst, tf_set;
    reg  [11:0] awa, ara;
    reg  [31:0] wd, tf_val;
    reg  [7:0]  code;
    wire        awr, wrdy, arr, bv, rv, go, blk, ld, rdy, wf, sk, act;
    wire [1:0]  br, rr;
    wire [31:0] rd_d, tf, nxt;
    integer     fail_count, cmp_count, cyc, k;
    reg  [7:0]  codes [0:4];

    arsc_start_compare #(.AW(12)) arsc_start_compare_i (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
        .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(br),
        .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
        .O_RDATA(rd_d), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rrdy),
        .I_TF_SECTOR(tf[7:0]), .I_TF_CYL_LOW(tf[15:8]), .I_TF_CYL_HIGH(tf[23:16]),
        .I_TF_DRV_HEAD(tf[31:24]), .I_CMD_WR(cmd_wr), .I_CMD_CODE(code),
        .I_SECTOR_DONE(sdone), .I_HOST_HW_RESET(hwrst), .O_AUTO_READ_GO(go),
        .O_AUTO_READ_BLOCK(blk), .O_TF_LOAD(ld), .O_TF_SECTOR_NXT(nxt[7:0]),
        .O_TF_CYL_LOW_NXT(nxt[15:8]), .O_TF_CYL_HIGH_NXT(nxt[23:16]),
        .O_TF_DRV_HEAD_NXT(nxt[31:24]), .O_DRIVE_READY(rdy), .O_WRITE_FAULT(wf),
        .O_SEEK_DONE(sk), .O_DRV0_STATUS_ACTIVE(act));

    arsc_host_tf arsc_host_tf_i (.i_clk(clk), .i_rst_b(rst_b), .i_set(tf_set),
        .i_set_val(tf_val), .i_load(ld), .i_nxt(nxt), .o_tf(tf));

    // ======================================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            stop_test;
        end
    end

    // ======================================================================
    // tasks
    task stop_test;
        begin
            if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // wide enough for a read response code above its data word
    task chk(input [33:0] g, input [33:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] i, input [7:0] d, input [1:0] e);
        begin
            @(posedge clk);
            awa <= {2'b00, i, 2'b00};
            wd <= {24'h00_0000, d};
            awv <= 1'b1;
            wv <= 1'b1;
            brdy <= 1'b1;
            do begin
                @(posedge clk);
                if (awv && awr) awv <= 1'b0;
                if (wv && wrdy) wv <= 1'b0;
            end while (!bv);
            brdy <= 1'b0;
            chk(br, e);
        end
    endtask
    task rd(input [7:0] i, input [7:0] d, input [1:0] e);
        begin
            @(posedge clk);
            ara <= {2'b00, i, 2'b00};
            arv <= 1'b1;
            rrdy <= 1'b1;
            do begin
                @(posedge clk);
                if (arv && arr) arv <= 1'b0;
            end while (!rv);
            rrdy <= 1'b0;
            chk({rr, rd_d}, {e, 24'h00_0000, d});
        end
    endtask
    task set_tf(input [31:0] v);
        begin
            @(posedge clk);
            tf_set <= 1'b1;
            tf_val <= v;
            @(posedge clk);
            tf_set <= 1'b0;
        end
    endtask
    // the answer pulse is looked for in the two cycles after the strobe is taken
    task cmd(input [7:0] c, input eg, input eb);
        reg g, b;
        begin
            @(posedge clk);
            cmd_wr <= 1'b1;
            code <= c;
            @(posedge clk);
            cmd_wr <= 1'b0;
            #1 g = go;
            b = blk;
            @(posedge clk);
            #1 g = g | go;
            b = b | blk;
            chk({g, b}, {eg, eb});
        end
    endtask
    task sec(input el, input [31:0] en);
        reg l;
        begin
            @(posedge clk);
            sdone <= 1'b1;
            @(posedge clk);
            sdone <= 1'b0;
            #1 l = ld;
            @(posedge clk);
            #1 l = l | ld;
            chk(l, el);
            if (el) chk(nxt, en);
        end
    endtask
    task stat(input [3:0] e);
        begin
            repeat (3) @(posedge clk);
            #1 chk({rdy, wf, sk, act}, e);
        end
    endtask

    // ======================================================================
    // main sequence
    initial begin
        {rst_b, awv, wv, brdy, arv, rrdy, cmd_wr, sdone, hwrst, tf_set} = 10'h000;
        {awa, ara, wd, tf_val, code} = 96'h0;
        {fail_count, cmp_count, cyc} = 96'h0;
        codes[0] = 8'h20; codes[1] = 8'h21; codes[2] = 8'hC4;
        codes[3] = 8'hC8; codes[4] = 8'hC9;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(`ARSC_IDX_DRV0_STATUS, 8'h00, `ARSC_RESP_OKAY);
        rd(`ARSC_IDX_ST_DRV_HEAD, 8'h00, `ARSC_RESP_OKAY);
        wr(8'h10, 8'h55, `ARSC_RESP_SLVERR);
        rd(8'h10, 8'h00, `ARSC_RESP_SLVERR);
        wr(`ARSC_IDX_ST_CYL_LOW, 8'h12, `ARSC_RESP_OKAY);
        rd(`ARSC_IDX_ST_CYL_LOW, 8'h00, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_CONTROL, 8'hF0, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_ST_CYL_LOW, 8'h12, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_ST_CYL_HIGH, 8'h34, `ARSC_RESP_OKAY);
        rd(`ARSC_IDX_ST_CYL_HIGH, 8'h34, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_CONTROL, 8'hE0, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_ST_DRV_HEAD, 8'h05, `ARSC_RESP_OKAY);
        rd(`ARSC_IDX_ST_DRV_HEAD, 8'h05, `ARSC_RESP_OKAY);
        set_tf(32'hE534_1201);
        cmd(8'h20, 1'b1, 1'b0);
        rd(`ARSC_IDX_ST_DRV_HEAD, 8'hE5, `ARSC_RESP_OKAY);
        for (k = 0; k < 5; k = k + 1) cmd(codes[k], 1'b1, 1'b0);
        cmd(8'hEC, 1'b0, 1'b0);
        set_tf(32'hE534_1301);
        cmd(8'h20, 1'b0, 1'b1);
        rd(`ARSC_IDX_ST_CYL_LOW, 8'h13, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_CONTROL, 8'h84, `ARSC_RESP_OKAY);
        set_tf(32'hE534_1401);
        cmd(8'hC8, 1'b0, 1'b1);
        rd(`ARSC_IDX_ST_CYL_LOW, 8'h13, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_CONTROL, 8'h41, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_ST_DRV_HEAD, 8'h05, `ARSC_RESP_OKAY);
        set_tf(32'h4534_1301);
        cmd(8'h20, 1'b0, 1'b1);
        rd(`ARSC_IDX_RESULT, 8'h02, `ARSC_RESP_OKAY);
        cmd(8'h20, 1'b1, 1'b0);
        rd(`ARSC_IDX_RESULT, 8'h03, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_CONTROL, 8'h00, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_SEC_LIM_0, 8'h10, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_SEC_LIM_1, 8'h05, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_HEAD_LIMITS, 8'h72, `ARSC_RESP_OKAY);
        rd(`ARSC_IDX_HEAD_LIMITS, 8'h72, `ARSC_RESP_OKAY);
        set_tf(32'hA200_FF10);
        sec(1'b1, 32'hA001_0001);
        rd(`ARSC_IDX_ST_CYL_HIGH, 8'h01, `ARSC_RESP_OKAY);
        rd(`ARSC_IDX_ST_DRV_HEAD, 8'hA0, `ARSC_RESP_OKAY);
        sec(1'b1, 32'hA001_0002);
        set_tf(32'hB301_0005);
        sec(1'b1, 32'hB401_0001);
        set_tf(32'hB701_0005);
        sec(1'b1, 32'hB001_0101);
        wr(`ARSC_IDX_CONTROL, 8'h01, `ARSC_RESP_OKAY);
        set_tf(32'hE3FF_FFFF);
        sec(1'b1, 32'hE400_0000);
        rd(`ARSC_IDX_ST_DRV_HEAD, 8'hB4, `ARSC_RESP_OKAY);
        wr(`ARSC_IDX_CONTROL, 8'h08, `ARSC_RESP_OKAY);
        sec(1'b0, 32'h0);
        wr(`ARSC_IDX_DRV0_STATUS, 8'h05, `ARSC_RESP_OKAY);
        rd(`ARSC_IDX_DRV0_STATUS, 8'h05, `ARSC_RESP_OKAY);
        set_tf(32'hA000_0001);
        stat(4'hB);
        wr(`ARSC_IDX_DRV0_STATUS, 8'h02, `ARSC_RESP_OKAY);
        stat(4'h5);
        set_tf(32'hB000_0001);
        stat(4'h0);
        wr(`ARSC_IDX_CONTROL, 8'h02, `ARSC_RESP_OKAY);
        stat(4'h5);
        @(posedge clk);
        hwrst <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk({rdy, wf, sk, act}, 4'h1);
        hwrst <= 1'b0;
        rd(`ARSC_IDX_DRV0_STATUS, 8'h00, `ARSC_RESP_OKAY);
        stop_test;
    end
endmodule // test_arsc_start_compare

// ===== verilog/arsc_consts.vh
// constants for the auto-read start compare block: register indices, fields, codes
// assumes a 32-bit AXI4-Lite register bus where byte address = 4 * register index
`ifndef ARSC_CONSTS_VH
`define ARSC_CONSTS_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define ARSC_IDX_ST_CYL_LOW   8'hAE
`define ARSC_IDX_ST_CYL_HIGH  8'hAF
`define ARSC_IDX_ST_DRV_HEAD  8'hB0
`define ARSC_IDX_SEC_LIM_0    8'hB1
`define ARSC_IDX_SEC_LIM_1    8'hB2
`define ARSC_IDX_HEAD_LIMITS  8'hB3
`define ARSC_IDX_DRV0_STATUS  8'hB4
`define ARSC_IDX_CONTROL      8'hE0
`define ARSC_IDX_RESULT       8'hE1

// ==========================================================================
// control register fields
`define ARSC_CTL_LBA_EN       0
`define ARSC_CTL_MS_EN        1
`define ARSC_CTL_DIS_ST_UPD   2
`define ARSC_CTL_DIS_AUTO_UPD 3
`define ARSC_CTL_BUSY         4
`define ARSC_CTL_AR_EN_LO     5
`define ARSC_CTL_AR_EN_HI     7

// ==========================================================================
// drive/head byte fields
`define ARSC_DH_DRIVE         4
`define ARSC_DH_LBA           6
`define ARSC_DH_HEAD_HI       3
`define ARSC_DH_CHS_CMP_HI    4

// drive 0 status fields
`define ARSC_D0_READY         2
`define ARSC_D0_WFAULT        1
`define ARSC_D0_SEEK          0

// ==========================================================================
// read command codes
`define ARSC_CMD_READ_SEC     8'h20
`define ARSC_CMD_READ_SEC_NR  8'h21
`define ARSC_CMD_READ_MULT    8'hC4
`define ARSC_CMD_READ_DMA     8'hC8
`define ARSC_CMD_READ_DMA_NR  8'hC9

// ==========================================================================
// reset values and bus answers
`define ARSC_BYTE_ZERO        8'h00
`define ARSC_SECTOR_FIRST     8'h01
`define ARSC_HEAD_ZERO        4'h0
`define ARSC_RESP_OKAY        2'b00
`define ARSC_RESP_SLVERR      2'b10

`endif

// ===== verilog/arsc_start_compare.v
// auto-read start register compare, task-file address tracking and drive 0 status
// assumes task-file inputs and command strobes come from host logic on the same clock;
// the host hardware reset pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "arsc_consts.vh"

module arsc_start_compare #(
    parameter AW = 12
) (
    input  wire          I_CORE_CLK,
    input  wire          I_RST_B,
    // axi4-lite register bus
    input  wire [AW-1:0] I_AWADDR,
    input  wire          I_AWVALID,
    output wire          O_AWREADY,
    input  wire [31:0]   I_WDATA,
    input  wire [3:0]    I_WSTRB,
    input  wire          I_WVALID,
    output wire          O_WREADY,
    output reg  [1:0]    O_BRESP,
    output reg           O_BVALID,
    input  wire          I_BREADY,
    input  wire [AW-1:0] I_ARADDR,
    input  wire          I_ARVALID,
    output wire          O_ARREADY,
    output reg  [31:0]   O_RDATA,
    output reg  [1:0]    O_RRESP,
    output reg           O_RVALID,
    input  wire          I_RREADY,
    // host task file and command strobes
    input  wire [7:0]    I_TF_SECTOR,
    input  wire [7:0]    I_TF_CYL_LOW,
    input  wire [7:0]    I_TF_CYL_HIGH,
    input  wire [7:0]    I_TF_DRV_HEAD,
    input  wire          I_CMD_WR,
    input  wire [7:0]    I_CMD_CODE,
    input  wire          I_SECTOR_DONE,
    input  wire          I_HOST_HW_RESET,
    // results
    output reg           O_AUTO_READ_GO,
    output reg           O_AUTO_READ_BLOCK,
    output reg           O_TF_LOAD,
    output reg  [7:0]    O_TF_SECTOR_NXT,
    output reg  [7:0]    O_TF_CYL_LOW_NXT,
    output reg  [7:0]    O_TF_CYL_HIGH_NXT,
    output reg  [7:0]    O_TF_DRV_HEAD_NXT,
    output reg           O_DRIVE_READY,
    output reg           O_WRITE_FAULT,
    output reg           O_SEEK_DONE,
    output reg           O_DRV0_STATUS_ACTIVE
);

// ==========================================================================
// functions

function is_read_cmd;
    input [7:0] code;
    begin
        is_read_cmd = (code == `ARSC_CMD_READ_SEC)    || (code == `ARSC_CMD_READ_SEC_NR) ||
                      (code == `ARSC_CMD_READ_MULT)   || (code == `ARSC_CMD_READ_DMA)    ||
                      (code == `ARSC_CMD_READ_DMA_NR);
    end
endfunction

// byte address to register index; low two bits must be zero for a hit
function [7:0] reg_index;
    input [AW-1:0] addr;
    begin
        reg_index = addr[9:2];
    end
endfunction

function addr_mapped;
    input [AW-1:0] addr;
    reg   [7:0]    idx;
    begin
        idx = addr[9:2];
        addr_mapped = (addr[1:0] == 2'b00) && (addr[AW-1:10] == {(AW-10){1'b0}}) &&
                      ((idx == `ARSC_IDX_ST_CYL_LOW)  || (idx == `ARSC_IDX_ST_CYL_HIGH) ||
                       (idx == `ARSC_IDX_ST_DRV_HEAD) || (idx == `ARSC_IDX_SEC_LIM_0)   ||
                       (idx == `ARSC_IDX_SEC_LIM_1)   || (idx == `ARSC_IDX_HEAD_LIMITS) ||
                       (idx == `ARSC_IDX_DRV0_STATUS) || (idx == `ARSC_IDX_CONTROL)     ||
                       (idx == `ARSC_IDX_RESULT));
    end
endfunction

// ==========================================================================
// registers

reg  [7:0] st_cyl_low_r;
reg  [7:0] st_cyl_high_r;
reg  [7:0] st_drv_head_r;
reg  [7:0] sec_lim_0_r;
reg  [7:0] sec_lim_1_r;
reg  [7:0] head_limits_r;
reg  [2:0] drv0_status_r;
reg  [7:0] control_r;
reg  [1:0] result_r;

// ==========================================================================
// host hardware reset pin: three flops, second and third must agree

reg  [2:0] host_hardware_reset_sync_r;
reg        host_hardware_reset_lvl_r;

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        host_hardware_reset_sync_r <= 3'b000;
        host_hardware_reset_lvl_r  <= 1'b0;
    end else begin
        host_hardware_reset_sync_r <= {host_hardware_reset_sync_r[1:0], I_HOST_HW_RESET};
        if (host_hardware_reset_sync_r[1] == host_hardware_reset_sync_r[2]) begin
            host_hardware_reset_lvl_r <= host_hardware_reset_sync_r[2];
        end
    end
end

// ==========================================================================
// axi4-lite write channel: address and data taken in either order

reg  [AW-1:0] wr_addr_r;
reg  [7:0]    wr_data_r;
reg           wr_lane0_r;
reg           aw_got_r;
reg           w_got_r;
wire          aw_take = I_AWVALID && O_AWREADY;
wire          w_take  = I_WVALID && O_WREADY;
wire          wr_go   = aw_got_r && w_got_r;
wire          wr_ok   = wr_go && addr_mapped(wr_addr_r) && wr_lane0_r;
wire [7:0]    wr_idx  = reg_index(wr_addr_r);

assign O_AWREADY = !aw_got_r && !O_BVALID;
assign O_WREADY  = !w_got_r && !O_BVALID;

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        wr_addr_r  <= {AW{1'b0}};
        wr_data_r  <= `ARSC_BYTE_ZERO;
        wr_lane0_r <= 1'b0;
        aw_got_r   <= 1'b0;
        w_got_r    <= 1'b0;
        O_BVALID   <= 1'b0;
        O_BRESP    <= `ARSC_RESP_OKAY;
    end else begin
        if (aw_take) begin
            wr_addr_r <= I_AWADDR;
            aw_got_r  <= 1'b1;
        end
        if (w_take) begin
            wr_data_r  <= I_WDATA[7:0];
            wr_lane0_r <= I_WSTRB[0];
            w_got_r    <= 1'b1;
        end
        if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP  <= addr_mapped(wr_addr_r) ? `ARSC_RESP_OKAY : `ARSC_RESP_SLVERR;
        end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end
end

// ==========================================================================
// axi4-lite read channel

assign O_ARREADY = !O_RVALID;

reg  [7:0] rd_mux;
always @* begin
    case (reg_index(I_ARADDR))
        `ARSC_IDX_ST_CYL_LOW:  rd_mux = st_cyl_low_r;
        `ARSC_IDX_ST_CYL_HIGH: rd_mux = st_cyl_high_r;
        `ARSC_IDX_ST_DRV_HEAD: rd_mux = st_drv_head_r;
        `ARSC_IDX_SEC_LIM_0:   rd_mux = sec_lim_0_r;
        `ARSC_IDX_SEC_LIM_1:   rd_mux = sec_lim_1_r;
        `ARSC_IDX_HEAD_LIMITS: rd_mux = head_limits_r;
        `ARSC_IDX_DRV0_STATUS: rd_mux = {5'b00000, drv0_status_r};
        `ARSC_IDX_CONTROL:     rd_mux = control_r;
        `ARSC_IDX_RESULT:      rd_mux = {6'b000000, result_r};
        default:               rd_mux = `ARSC_BYTE_ZERO;
    endcase
end

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        O_RVALID <= 1'b0;
        O_RDATA  <= 32'h0000_0000;
        O_RRESP  <= `ARSC_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RDATA  <= addr_mapped(I_ARADDR) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        O_RRESP  <= addr_mapped(I_ARADDR) ? `ARSC_RESP_OKAY : `ARSC_RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
    end
end

// ==========================================================================
// mode decode and start compare

wire block_addressing_flag  = control_r[`ARSC_CTL_LBA_EN] && I_TF_DRV_HEAD[`ARSC_DH_LBA];
wire ar_any_en = |control_r[`ARSC_CTL_AR_EN_HI:`ARSC_CTL_AR_EN_LO];
wire read_cmd  = I_CMD_WR && is_read_cmd(I_CMD_CODE);

// in chs only drive and head take part; pass bits travel unchecked
wire dh_match  = block_addressing_flag ? (st_drv_head_r == I_TF_DRV_HEAD) :
                 (st_drv_head_r[`ARSC_DH_CHS_CMP_HI:0] ==
                  I_TF_DRV_HEAD[`ARSC_DH_CHS_CMP_HI:0]);
wire all_match = dh_match && (st_cyl_low_r == I_TF_CYL_LOW) &&
                 (st_cyl_high_r == I_TF_CYL_HIGH);

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        O_AUTO_READ_GO    <= 1'b0;
        O_AUTO_READ_BLOCK <= 1'b0;
        result_r          <= 2'b00;
    end else begin
        O_AUTO_READ_GO    <= read_cmd && ar_any_en && all_match;
        O_AUTO_READ_BLOCK <= read_cmd && ar_any_en && !all_match;
        if (read_cmd && ar_any_en) begin
            result_r <= {1'b1, all_match};
        end
    end
end

// ==========================================================================
// next address after a sector: chs wraps on limits, lba is one 28-bit count

wire       drv1      = I_TF_DRV_HEAD[`ARSC_DH_DRIVE];
wire [7:0] sec_lim   = drv1 ? sec_lim_1_r : sec_lim_0_r;
wire [3:0] head_lim  = drv1 ? head_limits_r[7:4] : head_limits_r[3:0];
wire [3:0] head_now  = I_TF_DRV_HEAD[`ARSC_DH_HEAD_HI:0];
wire [15:0] cyl_now  = {I_TF_CYL_HIGH, I_TF_CYL_LOW};
wire [27:0] lba_now  = {head_now, cyl_now, I_TF_SECTOR};
wire [27:0] lba_inc  = lba_now + 28'h000_0001;

reg  [7:0]  sec_nxt;
reg  [3:0]  head_nxt;
reg  [15:0] cyl_nxt;
always @* begin
    sec_nxt  = I_TF_SECTOR;
    head_nxt = head_now;
    cyl_nxt  = cyl_now;
    if (block_addressing_flag) begin
        sec_nxt  = lba_inc[7:0];
        cyl_nxt  = lba_inc[23:8];
        head_nxt = lba_inc[27:24];
    end else if (I_TF_SECTOR == sec_lim) begin
        sec_nxt = `ARSC_SECTOR_FIRST;
        if (head_now == head_lim) begin
            head_nxt = `ARSC_HEAD_ZERO;
            cyl_nxt  = cyl_now + 16'h0001;
        end else begin
            head_nxt = head_now + 4'h1;
        end
    end else begin
        sec_nxt = I_TF_SECTOR + 8'h01;
    end
end

// ==========================================================================
// task-file update strobe: every sector, the last one included

wire upd_ok = I_SECTOR_DONE && !control_r[`ARSC_CTL_DIS_AUTO_UPD];

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        O_TF_LOAD         <= 1'b0;
        O_TF_SECTOR_NXT   <= `ARSC_BYTE_ZERO;
        O_TF_CYL_LOW_NXT  <= `ARSC_BYTE_ZERO;
        O_TF_CYL_HIGH_NXT <= `ARSC_BYTE_ZERO;
        O_TF_DRV_HEAD_NXT <= `ARSC_BYTE_ZERO;
    end else begin
        O_TF_LOAD <= upd_ok;
        if (upd_ok) begin
            O_TF_SECTOR_NXT   <= sec_nxt;
            O_TF_CYL_LOW_NXT  <= cyl_nxt[7:0];
            O_TF_CYL_HIGH_NXT <= cyl_nxt[15:8];
            O_TF_DRV_HEAD_NXT <= {I_TF_DRV_HEAD[7:4], head_nxt};
        end
    end
end

// ==========================================================================
// start registers and software-written registers
// a software write in the same cycle as a hardware load wins: it came later in intent

wire st_hw_ok = !control_r[`ARSC_CTL_DIS_ST_UPD];
wire st_load  = read_cmd && st_hw_ok;
wire st_track = upd_ok && st_hw_ok;
wire busy     = control_r[`ARSC_CTL_BUSY];

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        st_cyl_low_r  <= `ARSC_BYTE_ZERO;
        st_cyl_high_r <= `ARSC_BYTE_ZERO;
        st_drv_head_r <= `ARSC_BYTE_ZERO;
        sec_lim_0_r   <= `ARSC_BYTE_ZERO;
        sec_lim_1_r   <= `ARSC_BYTE_ZERO;
        head_limits_r <= `ARSC_BYTE_ZERO;
        control_r     <= `ARSC_BYTE_ZERO;
    end else begin
        if (st_load) begin
            st_cyl_low_r  <= I_TF_CYL_LOW;
            st_cyl_high_r <= I_TF_CYL_HIGH;
            st_drv_head_r <= I_TF_DRV_HEAD;
        end else if (st_track) begin
            st_cyl_low_r  <= cyl_nxt[7:0];
            st_cyl_high_r <= cyl_nxt[15:8];
            if (block_addressing_flag) begin
                st_drv_head_r[`ARSC_DH_HEAD_HI:0] <= head_nxt;
            end else begin
                st_drv_head_r <= {I_TF_DRV_HEAD[7:4], head_nxt};
            end
        end
        if (wr_ok) begin
            case (wr_idx)
                // writes to the cylinder pair outside busy are dropped, not faulted
                `ARSC_IDX_ST_CYL_LOW:  if (busy) st_cyl_low_r <= wr_data_r;
                `ARSC_IDX_ST_CYL_HIGH: if (busy) st_cyl_high_r <= wr_data_r;
                `ARSC_IDX_ST_DRV_HEAD: st_drv_head_r <= wr_data_r;
                `ARSC_IDX_SEC_LIM_0:   sec_lim_0_r   <= wr_data_r;
                `ARSC_IDX_SEC_LIM_1:   sec_lim_1_r   <= wr_data_r;
                `ARSC_IDX_HEAD_LIMITS: head_limits_r <= wr_data_r;
                `ARSC_IDX_CONTROL:     control_r     <= wr_data_r;
                default:               control_r     <= control_r;
            endcase
        end
    end
end

// ==========================================================================
// drive 0 status: cleared by the host reset pin as well as power-on

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        drv0_status_r <= 3'b000;
    end else if (host_hardware_reset_lvl_r) begin
        drv0_status_r <= 3'b000;
    end else if (wr_ok && (wr_idx == `ARSC_IDX_DRV0_STATUS)) begin
        drv0_status_r <= wr_data_r[2:0];
    end
end

// with two physical drives one register answers for both
wire d0_active = !drv1 || control_r[`ARSC_CTL_MS_EN];

always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
        O_DRIVE_READY        <= 1'b0;
        O_WRITE_FAULT        <= 1'b0;
        O_SEEK_DONE          <= 1'b0;
        O_DRV0_STATUS_ACTIVE <= 1'b0;
    end else begin
        O_DRV0_STATUS_ACTIVE <= d0_active;
        O_DRIVE_READY        <= d0_active && drv0_status_r[`ARSC_D0_READY];
        O_WRITE_FAULT        <= d0_active && drv0_status_r[`ARSC_D0_WFAULT];
        O_SEEK_DONE          <= d0_active && drv0_status_r[`ARSC_D0_SEEK];
    end
end

endmodule // arsc_start_compare
